// ---- dv/audio_sink_model.sv ----
/* Sample sink on one output stream, prompt or stalled.
 Assumes valid/ready sampled at the rising sys_clk edge. */
`timescale 1ns/1ps
`default_nettype none
module audio_sink_model (
    input wire logic sys_clk,
    input wire logic stall,
    input wire logic outValid,
    input wire logic [15:0] outData,
    output logic outReady
);
    logic [15:0] got[$];
    // Stall drops ready so the FIFO can fill up
    assign outReady = !stall;
    // Accepted samples kept in arrival order
    always @(posedge sys_clk) begin
        if (outValid && outReady) got.push_back(outData);
    end
endmodule
`default_nettype wire

// ---- dv/dyn_comp_assertions.sv ----
/* Port checker for the compressor.
 Assumes it is bound into the top module, one clock, async reset. */
`timescale 1ns/1ps
`default_nettype none
module dyn_comp_assertions #(parameter W = 16) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [15:0] regRdData,
    input wire logic [W-1:0] adcInData,
    input wire logic adcInValid,
    input wire logic adcInReady,
    input wire logic [W-1:0] adcOutData,
    input wire logic adcOutValid,
    input wire logic [W-1:0] dacInData,
    input wire logic dacInValid,
    input wire logic dacInReady,
    input wire logic [W-1:0] dacOutData,
    input wire logic dacOutValid
);
    logic en_r, path_r;
    logic [3:0] lim_r;
    logic [5:0] slope_r;
    logic [10:0] knee_r;
    logic [7:0] maxU, minU;
    // Shadow of the controls, so read-back needs no peeking inside
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            {en_r, path_r, lim_r, slope_r, knee_r} <= {2'h0, 4'h8, 6'h00, 11'h000};
        end else if (regWrEn) begin
            if (regAddr == 8'h28) {en_r, path_r} <= regWrData[15:14];
            if (regAddr == 8'h29) lim_r <= regWrData[3:0];
            if (regAddr == 8'h2A) slope_r <= regWrData[5:0];
            if (regAddr == 8'h2B) knee_r <= regWrData[10:0];
        end
    end
    // Gain limits in 0.75dB units
    assign maxU = (lim_r[1:0] == 2'h3) ? 8'h30 : 8'h10 + {3'h0, lim_r[1:0], 3'h0};
    assign minU = {3'h0, lim_r[3:2], 3'h0};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_adc_pass;
        adcInValid && adcInReady && !adcOutValid && !(en_r && !path_r) |=> adcOutData == $past(adcInData);
    endproperty
    a_adc_pass: assert property (p_adc_pass) else $error("record sample altered in bypass");
    property p_dac_pass;
        dacInValid && dacInReady && !dacOutValid && !(en_r && path_r) |=> dacOutData == $past(dacInData);
    endproperty
    a_dac_pass: assert property (p_dac_pass) else $error("playback sample altered off path");
    property p_unity;
        adcInValid && adcInReady && !adcOutValid && slope_r == 6'h00 && knee_r == 11'h000
            |=> adcOutData == $past(adcInData);
    endproperty
    a_unity: assert property (p_unity) else $error("unity slope changed gain");
    property p_ctl0_rb;
        $past(regRdEn && regAddr == 8'h28) |-> regRdData == {en_r, path_r, 14'h0000};
    endproperty
    a_ctl0_rb: assert property (p_ctl0_rb) else $error("control zero read-back");
    property p_lim_rb;
        $past(regRdEn && regAddr == 8'h29) |-> regRdData == {12'h000, lim_r};
    endproperty
    a_lim_rb: assert property (p_lim_rb) else $error("gain limit read-back");
    property p_slope_rb;
        $past(regRdEn && regAddr == 8'h2A) |-> regRdData == {10'h000, slope_r};
    endproperty
    a_slope_rb: assert property (p_slope_rb) else $error("slope read-back");
    property p_knee_rb;
        $past(regRdEn && regAddr == 8'h2B) |-> regRdData == {5'h00, knee_r};
    endproperty
    a_knee_rb: assert property (p_knee_rb) else $error("knee read-back");
    property p_gain_lim;
        $past(regRdEn && regAddr == 8'h2C)
            |-> $signed(regRdData[7:0]) <= $signed(maxU) && $signed(regRdData[7:0]) >= -$signed(minU);
    endproperty
    a_gain_lim: assert property (p_gain_lim) else $error("applied gain outside limits");
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
/* Self-checking bench: registers, bypass, gain curve, FIFO fill.
 Assumes checker and sink model compiled before it. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin badCount++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
    logic sys_clk = 0, rst = 1, regWrEn = 0, regRdEn = 0, adcInValid = 0, dacInValid = 0, adcStall = 0, dacStall = 0;
    logic [7:0] regAddr = 8'h00;
    logic [15:0] regWrData = 16'h0000, adcInData = 16'h0000, dacInData = 16'h0000;
    wire logic [15:0] regRdData, adcOutData, dacOutData;
    wire logic adcInReady, adcOutValid, adcOutReady, dacInReady, dacOutValid, dacOutReady;
    int badCount = 0, checked = 0;
    // Clock, 10 ns
    always #5 sys_clk = ~sys_clk;
    dynamic_range_compressor u_dynamic_range_compressor (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .adcInData(adcInData), .adcInValid(adcInValid), .adcInReady(adcInReady), .adcOutData(adcOutData),
        .adcOutValid(adcOutValid), .adcOutReady(adcOutReady), .dacInData(dacInData), .dacInValid(dacInValid),
        .dacInReady(dacInReady), .dacOutData(dacOutData), .dacOutValid(dacOutValid), .dacOutReady(dacOutReady));
    audio_sink_model u_audio_sink_model_adc (.sys_clk(sys_clk), .stall(adcStall), .outValid(adcOutValid),
        .outData(adcOutData), .outReady(adcOutReady));
    audio_sink_model u_audio_sink_model_dac (.sys_clk(sys_clk), .stall(dacStall), .outValid(dacOutValid),
        .outData(dacOutData), .outReady(dacOutReady));
    task automatic close_out;
        $display("compares %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic reset_dut(input int n);
        rst <= 1;
        repeat (n) @(posedge sys_clk);
        rst <= 0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        {regAddr, regWrData, regWrEn} <= {a, d, 1'b1};
        @(posedge sys_clk);
        regWrEn <= 0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        {regAddr, regRdEn} <= {a, 1'b1};
        @(posedge sys_clk);
        regRdEn <= 0;
        #1 `CHK(regRdData, exp)
    endtask
    // Hold valid until ready is seen at the taking edge
    task automatic push(input bit dac, input logic [15:0] d);
        @(posedge sys_clk);
        if (dac) {dacInData, dacInValid} <= {d, 1'b1};
        else {adcInData, adcInValid} <= {d, 1'b1};
        @(negedge sys_clk);
        while (!(dac ? dacInReady : adcInReady)) @(negedge sys_clk);
        @(posedge sys_clk);
        if (dac) dacInValid <= 0;
        else adcInValid <= 0;
    endtask
    task automatic pull(input bit dac, input logic [15:0] exp);
        int n;
        logic [15:0] v;
        n = 0;
        while ((dac ? u_audio_sink_model_dac.got.size() : u_audio_sink_model_adc.got.size()) == 0 && n < 50) begin
            @(posedge sys_clk);
            n++;
        end
        #1 v = dac ? u_audio_sink_model_dac.got.pop_front() : u_audio_sink_model_adc.got.pop_front();
        `CHK(v, exp)
    endtask
    task automatic t_regs;
        rd(8'h28, 16'h0000);
        rd(8'h29, 16'h0008);
        rd(8'h2A, 16'h0000);
        rd(8'h2B, 16'h0000);
        rd(8'h30, 16'h0000);
        wr(8'h2B, 16'hFFFF);
        rd(8'h2B, 16'h07FF);
        wr(8'h2A, 16'hFFFF);
        rd(8'h2A, 16'h003F);
        $display("regs done");
    endtask
    task automatic t_bypass;
        reset_dut(2);
        wr(8'h28, 16'h4000);
        push(0, 16'h8001);
        pull(0, 16'h8001);
        push(1, 16'h7FFF);
        pull(1, 16'h7FFF);
        reset_dut(2);
        wr(8'h28, 16'h8000);
        push(0, 16'h1234);
        pull(0, 16'h1234);
        $display("bypass done");
    endtask
    // Full scale at zero upper slope lands on knee out; half slope then gives 0dB
    task automatic t_upper;
        reset_dut(2);
        wr(8'h2B, 16'h0208);
        wr(8'h2A, 16'h0028);
        wr(8'h28, 16'h8000);
        push(0, 16'h7FFF);
        pull(0, 16'h3FFF);
        rd(8'h2C, 16'h00F8);
        push(1, 16'h4000);
        pull(1, 16'h4000);
        wr(8'h2A, 16'h0008);
        push(0, 16'h7FFF);
        pull(0, 16'h7FFF);
        rd(8'h2C, 16'h0000);
        $display("upper done");
    endtask
    // Quiet input, zero lower slope: boost stops at the maximum
    task automatic t_lower;
        reset_dut(2);
        wr(8'h2A, 16'h0004);
        wr(8'h28, 16'hC000);
        push(1, 16'h0400);
        pull(1, 16'h1000);
        rd(8'h2C, 16'h0010);
        push(0, 16'h0400);
        pull(0, 16'h0400);
        wr(8'h29, 16'h0001);
        push(1, 16'h0400);
        pull(1, 16'h2000);
        rd(8'h2C, 16'h0018);
        $display("lower done");
    endtask
    task automatic t_fifo;
        reset_dut(2);
        adcStall <= 1;
        for (int i = 1; i <= 8; i++) push(0, 16'(i * 16'h0111));
        @(negedge sys_clk);
        `CHK(adcInReady, 1'b0)
        `CHK(dacInReady, 1'b1)
        @(posedge sys_clk);
        adcStall <= 0;
        for (int i = 1; i <= 8; i++) pull(0, 16'(i * 16'h0111));
        $display("fifo done");
    endtask
    // Main sequence
    initial begin
        reset_dut(10);
        t_regs();
        t_bypass();
        t_upper();
        t_lower();
        t_fifo();
        close_out();
    end
    // Watchdog far beyond the expected couple of hundred cycles
    initial begin
        #200000;
        badCount++;
        close_out();
    end
endmodule
bind dynamic_range_compressor dyn_comp_assertions #(.W(W)) u_dyn_comp_assertions (.sys_clk(sys_clk), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .adcInData(adcInData), .adcInValid(adcInValid), .adcInReady(adcInReady), .adcOutData(adcOutData),
    .adcOutValid(adcOutValid), .dacInData(dacInData), .dacInValid(dacInValid), .dacInReady(dacInReady),
    .dacOutData(dacOutData), .dacOutValid(dacOutValid));
`default_nettype wire

// ---- src/dyn_comp_regs.vh ----
/*
 Register map, field positions, reset values and gain-table constants
 of the dynamic range compressor. Assumes an 8-bit register address
 and 16-bit register data; included by bare name.
*/
`ifndef DYN_COMP_REGS_VH
`define DYN_COMP_REGS_VH

`define OFS_CTRL0 8'h28
`define OFS_CTRL1 8'h29
`define OFS_SLOPE 8'h2A
`define OFS_KNEE 8'h2B
`define OFS_STATUS 8'h2C

`define BIT_ENABLE 15
`define BIT_PATH 14
`define FLD_MINGAIN 3:2
`define FLD_MAXGAIN 1:0
`define FLD_HISLOPE 5:3
`define FLD_LOSLOPE 2:0
`define FLD_KNEEIN 10:5
`define FLD_KNEEOUT 4:0

`define RST_MINGAIN 2'h2
`define RST_MAXGAIN 2'h0
`define RST_SLOPE 3'h0
`define RST_KNEEIN 6'h00
`define RST_KNEEOUT 5'h00

// Level and gain run in 0.75dB units, eight units per octave
`define UNITS_PER_OCT 8
`define ENV_LEAK_SHIFT 8

`endif

// ---- src/dynamic_range_compressor.v ----
/*
 Dynamic range compressor gain stage with its register slave and an
 8-word sample FIFO on each of the record and playback streams.
 Assumes one 100 MHz clock, inputs synchronous to it, and samples
 arriving as signed two's-complement words with valid/ready.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dyn_comp_regs.vh"

module sample_fifo #(
    parameter W = 16,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire sys_clk,
    input wire rst,
    input wire [W-1:0] inData,
    input wire inValid,
    output wire inReady,
    output wire [W-1:0] outData,
    output wire outValid,
    input wire outReady
);
    localparam integer LAST_I = DEPTH - 1;
    // Occupancy and index limits cut to their own widths
    localparam [AW:0] FULL = DEPTH[AW:0];
    localparam [AW-1:0] LAST = LAST_I[AW-1:0];
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr_r;
    reg [AW-1:0] rdPtr_r;
    reg [AW:0] count_r;
    wire push;
    wire pop;

    // Full and empty straight from the occupancy count
    assign inReady = (count_r != FULL);
    assign outValid = (count_r != {(AW+1){1'b0}});
    assign outData = mem[rdPtr_r];
    assign push = inValid & inReady;
    assign pop = outValid & outReady;

    // Storage is not reset; only pointers and count are
    always @(posedge sys_clk) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end

    // Pointers wrap at DEPTH, so DEPTH need not be a power of two
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wrPtr_r <= {AW{1'b0}};
            rdPtr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wrPtr_r <= (wrPtr_r == LAST) ? {AW{1'b0}} : wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= (rdPtr_r == LAST) ? {AW{1'b0}} : rdPtr_r + 1'b1;
            end
            if (push & ~pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop & ~push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule

module dynamic_range_compressor #(
    parameter W = 16,
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW = 3
) (
    input wire sys_clk,
    input wire rst,
    input wire [7:0] regAddr,
    input wire [15:0] regWrData,
    input wire regWrEn,
    input wire regRdEn,
    output reg [15:0] regRdData,
    input wire [W-1:0] adcInData,
    input wire adcInValid,
    output wire adcInReady,
    output wire [W-1:0] adcOutData,
    output wire adcOutValid,
    input wire adcOutReady,
    input wire [W-1:0] dacInData,
    input wire dacInValid,
    output wire dacInReady,
    output wire [W-1:0] dacOutData,
    output wire dacOutValid,
    input wire dacOutReady
);
    reg compressorEnable_r;
    reg compressorPathSelect_r;
    reg [1:0] minGainLimit_r;
    reg [1:0] maxGainLimit_r;
    reg [2:0] upperRegionSlope_r;
    reg [2:0] lowerRegionSlope_r;
    reg [5:0] kneeInputLevel_r;
    reg [4:0] kneeOutputLevel_r;
    reg [W-1:0] env_r;
    reg [7:0] gainNow_r;

    // Slope applied to a non-negative level distance
    function [11:0] applySlope;
        input [11:0] d;
        input [2:0] code;
        input upper;
        begin
            case (code)
                3'h0: applySlope = d;
                3'h1: applySlope = d >> 1;
                3'h2: applySlope = d >> 2;
                3'h3: applySlope = d >> 3;
                3'h4: applySlope = upper ? (d >> 4) : 12'h000;
                default: applySlope = 12'h000; // Zero slope; reserved codes fall here too
            endcase
        end
    endfunction

    // Level in 0.75dB units below full scale, from leading one and three mantissa bits
    function [11:0] levelCode;
        input [W-1:0] mag;
        integer i;
        integer p;
        integer sh;
        reg [W-1:0] norm;
        reg [11:0] oct;
        begin
            p = -1;
            norm = {W{1'b0}};
            oct = 12'h000;
            for (i = 0; i < W-1; i = i + 1) begin
                if (mag[i]) begin
                    p = i;
                end
            end
            if (p < 0) begin
                levelCode = 12'h07F; // Silence: deepest level
            end else begin
                sh = W - 2 - p;
                norm = mag << sh;
                oct = sh[11:0];
                levelCode = (oct << 3) + {9'h000, ~norm[W-3:W-5]};
            end
        end
    endfunction

    // Gain limits in 0.75dB units
    function [11:0] minLimit;
        input [1:0] code;
        begin
            case (code)
                2'h0: minLimit = 12'h000;
                2'h1: minLimit = 12'hFF8;
                2'h2: minLimit = 12'hFF0;
                default: minLimit = 12'hFE8;
            endcase
        end
    endfunction

    function [11:0] maxLimit;
        input [1:0] code;
        begin
            case (code)
                2'h0: maxLimit = 12'h010;
                2'h1: maxLimit = 12'h018;
                2'h2: maxLimit = 12'h020;
                default: maxLimit = 12'h030;
            endcase
        end
    endfunction

    // Linear mantissa 2^(f/8) in Q1.7
    function [7:0] mantissa;
        input [2:0] f;
        begin
            case (f)
                3'h0: mantissa = 8'h80;
                3'h1: mantissa = 8'h8C;
                3'h2: mantissa = 8'h98;
                3'h3: mantissa = 8'hA6;
                3'h4: mantissa = 8'hB5;
                3'h5: mantissa = 8'hC5;
                3'h6: mantissa = 8'hD7;
                default: mantissa = 8'hEA;
            endcase
        end
    endfunction

    // Register writes; reserved codes are stored as written
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            compressorEnable_r <= 1'b0;
            compressorPathSelect_r <= 1'b0;
            minGainLimit_r <= `RST_MINGAIN;
            maxGainLimit_r <= `RST_MAXGAIN;
            upperRegionSlope_r <= `RST_SLOPE;
            lowerRegionSlope_r <= `RST_SLOPE;
            kneeInputLevel_r <= `RST_KNEEIN;
            kneeOutputLevel_r <= `RST_KNEEOUT;
        end else if (regWrEn) begin
            case (regAddr)
                `OFS_CTRL0: begin
                    compressorEnable_r <= regWrData[`BIT_ENABLE];
                    compressorPathSelect_r <= regWrData[`BIT_PATH];
                end
                `OFS_CTRL1: begin
                    minGainLimit_r <= regWrData[`FLD_MINGAIN];
                    maxGainLimit_r <= regWrData[`FLD_MAXGAIN];
                end
                `OFS_SLOPE: begin
                    upperRegionSlope_r <= regWrData[`FLD_HISLOPE];
                    lowerRegionSlope_r <= regWrData[`FLD_LOSLOPE];
                end
                `OFS_KNEE: begin
                    kneeInputLevel_r <= regWrData[`FLD_KNEEIN];
                    kneeOutputLevel_r <= regWrData[`FLD_KNEEOUT];
                end
                default: begin
                end
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            regRdData <= 16'h0000;
        end else if (regRdEn) begin
            case (regAddr)
                `OFS_CTRL0: regRdData <= {compressorEnable_r, compressorPathSelect_r, 14'h0000};
                `OFS_CTRL1: regRdData <= {12'h000, minGainLimit_r, maxGainLimit_r};
                `OFS_SLOPE: regRdData <= {10'h000, upperRegionSlope_r, lowerRegionSlope_r};
                `OFS_KNEE: regRdData <= {5'h00, kneeInputLevel_r, kneeOutputLevel_r};
                `OFS_STATUS: regRdData <= {8'h00, gainNow_r};
                default: regRdData <= 16'h0000;
            endcase
        end else begin
            regRdData <= 16'h0000;
        end
    end

    wire compOnDac = compressorPathSelect_r;
    wire [W-1:0] compIn = compOnDac ? dacInData : adcInData;
    wire compFire = compressorEnable_r & (compOnDac ? (dacInValid & dacInReady) : (adcInValid & adcInReady));
    wire [W-1:0] absIn = compIn[W-1] ? (~compIn + 1'b1) : compIn;
    wire [W-1:0] magIn = absIn[W-1] ? {1'b0, {(W-1){1'b1}}} : absIn; // Clip -FS onto +FS
    wire [W-1:0] lvl = (magIn > env_r) ? magIn : env_r;

    reg signed [11:0] x;
    reg signed [11:0] k;
    reg signed [11:0] o;
    reg signed [11:0] yAtt;
    reg signed [11:0] g;
    reg signed [11:0] sa;
    reg signed [W+8:0] prod;
    reg signed [W+19:0] scaled;
    reg signed [W+19:0] q;
    reg [W-1:0] compOut;

    // Static curve in level units, then dB gain to linear multiply
    always @* begin
        x = levelCode(lvl);
        k = {6'h00, kneeInputLevel_r};
        o = {7'h00, kneeOutputLevel_r};
        if (x < k) begin
            yAtt = o - $signed(applySlope(k - x, upperRegionSlope_r, 1'b1));
        end else begin
            yAtt = o + $signed(applySlope(x - k, lowerRegionSlope_r, 1'b0));
        end
        // unit slope keeps gain, zero slope pins output
        g = x - yAtt;
        if (g < $signed(minLimit(minGainLimit_r))) begin
            g = minLimit(minGainLimit_r);
        end else if (g > $signed(maxLimit(maxGainLimit_r))) begin
            g = maxLimit(maxGainLimit_r);
        end
        sa = (g >>> 3) + 12'sd3; // Octave shift, 0..9 after the -3 floor
        prod = $signed(compIn) * $signed({1'b0, mantissa(g[2:0])});
        scaled = {{11{prod[W+8]}}, prod} <<< sa[3:0];
        q = scaled >>> 10;
        if (q > $signed({{20{1'b0}}, 1'b0, {(W-1){1'b1}}})) begin
            compOut = {1'b0, {(W-1){1'b1}}};
        end else if (q < $signed({{20{1'b1}}, 1'b1, {(W-1){1'b0}}})) begin
            compOut = {1'b1, {(W-1){1'b0}}};
        end else begin
            compOut = q[W-1:0];
        end
    end

    // Peak-hold level estimate with slow leak; attack and decay shaping are not modelled
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            env_r <= {W{1'b0}};
            gainNow_r <= 8'h00;
        end else if (compFire) begin
            env_r <= lvl - (lvl >> `ENV_LEAK_SHIFT);
            gainNow_r <= g[7:0];
        end
    end

    wire [W-1:0] adcFifoIn = (compressorEnable_r & ~compOnDac) ? compOut : adcInData;
    wire [W-1:0] dacFifoIn = (compressorEnable_r & compOnDac) ? compOut : dacInData;

    // Both streams buffered alike so bypass adds no latency change
    sample_fifo #(.W(W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) adcFifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .inData(adcFifoIn),
        .inValid(adcInValid),
        .inReady(adcInReady),
        .outData(adcOutData),
        .outValid(adcOutValid),
        .outReady(adcOutReady)
    );

    sample_fifo #(.W(W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) dacFifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .inData(dacFifoIn),
        .inValid(dacInValid),
        .inReady(dacInReady),
        .outData(dacOutData),
        .outValid(dacOutValid),
        .outReady(dacOutReady)
    );
endmodule
`default_nettype wire
